// ---- verilog/amss_pkg.sv ----
// package of constants for the audio mute source select block
//
// Overview of operation
// - three 3-bit read/write selectors at bits 2:0, each reset to zero
// - code 000 drives the port mute input with constant zero
// - code 001 selects port0 data line 7 shared with second spi clock
// - code 010 selects pin shared by data lines and second spi slave-out
// - code 011 selects pin shared by data lines and second spi slave-in
// - code 101 selects first spi slave-in pin
// - code 110 selects first spi chip select shared with second i2c clock
// - code 111 selects first spi enable shared with second i2c data
// - bits 31:3 reserved; reads zero here, software writes zeros
// - transmit bit clock internal, external input or output from mode and direction
// - receive bit clock classified by the same mode and direction scheme
package amss_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [31:0] AMSS_ADDR_PORT0 = 32'h4000_0018;
    localparam logic [31:0] AMSS_ADDR_PORT1 = 32'h4000_001C;
    localparam logic [31:0] AMSS_ADDR_PORT2 = 32'h4000_0020;
    localparam logic [31:0] AMSS_ADDR_CLKMODE = 32'h4000_0024;
    localparam int          AMSS_NPORTS      = 3;
    localparam int          AMSS_SEL_W       = 3;
    localparam logic [2:0]  AMSS_SEL_RESET   = 3'h0;

    // ------------------------------------------------------------
    // selector codes
    // ------------------------------------------------------------
    localparam logic [2:0] AMSS_SEL_ZERO   = 3'h0;
    localparam logic [2:0] AMSS_SEL_D7     = 3'h1;
    localparam logic [2:0] AMSS_SEL_D8     = 3'h2;
    localparam logic [2:0] AMSS_SEL_D9     = 3'h3;
    localparam logic [2:0] AMSS_SEL_RSVD   = 3'h4;
    localparam logic [2:0] AMSS_SEL_S0SIMO = 3'h5;
    localparam logic [2:0] AMSS_SEL_S0SCS  = 3'h6;
    localparam logic [2:0] AMSS_SEL_S0ENA  = 3'h7;

    // ------------------------------------------------------------
    // bit clock classes, one-hot
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        AMSS_CLK_EXT_IN  = 3'b001,
        AMSS_CLK_EXT_OUT = 3'b010,
        AMSS_CLK_INT     = 3'b100
    } amss_clk_class_t;

    localparam int AMSS_CM_TXM  = 0;
    localparam int AMSS_CM_TXD  = 1;
    localparam int AMSS_CM_RXM  = 2;
    localparam int AMSS_CM_RXD  = 3;

endpackage

// ---- verilog/amss_sync.sv ----
// two-stage synchronizer for one mute source
module amss_sync
    import amss_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic din,
    output logic      dout
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic s1;
        logic s2;
    } amss_sync_st_t;

    amss_sync_st_t st;
    amss_sync_st_t next_st;

    always_comb begin
        next_st    = st;
        next_st.s1 = din;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.s2;

endmodule // amss_sync

// ---- verilog/amss_clkclass.sv ----
// classifier of a bit clock from its mode and direction bits
module amss_clkclass
    import amss_pkg::*;
(
    input  wire logic      mode,
    input  wire logic      dir_out,
    output amss_clk_class_t cls
);

    always_comb begin
        if (mode && dir_out) begin
            cls = AMSS_CLK_INT;
        end else if (!mode && dir_out) begin
            cls = AMSS_CLK_EXT_OUT;
        end else begin
            // mode 1 with input direction is undefined; treated as input
            cls = AMSS_CLK_EXT_IN;
        end
    end

endmodule // amss_clkclass

// ---- verilog/amss_top.sv ----
// audio mute source select: apb registers, source mux and synchronizers
module amss_top
    import amss_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        data7_second_spi_clock_pin,
    input  wire logic        data8_second_spi_slave_out_pin,
    input  wire logic        data9_second_spi_slave_in_pin,
    input  wire logic        first_spi_slave_in_pin,
    input  wire logic        first_spi_chip_select_i2c_clock_pin,
    input  wire logic        first_spi_enable_i2c_data_pin,
    output logic             mute_in_port0,
    output logic             mute_in_port1,
    output logic             mute_in_port2,
    output logic [2:0]       transmit_clock_class,
    output logic [2:0]       receive_clock_class
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [AMSS_NPORTS-1:0][AMSS_SEL_W-1:0] sel;
        logic [3:0]                             clkmode;
        logic [31:0]                            rdata;
        logic                                   ready;
        logic                                   err;
        logic [AMSS_NPORTS-1:0]                 mute;
        logic [2:0]                             txcls;
        logic [2:0]                             rxcls;
    } amss_st_t;

    amss_st_t st;
    amss_st_t next_st;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic int amss_port_index(input logic [31:0] a);
        if (a == AMSS_ADDR_PORT0) begin
            return 0;
        end else if (a == AMSS_ADDR_PORT1) begin
            return 1;
        end else if (a == AMSS_ADDR_PORT2) begin
            return 2;
        end
        return -1;
    endfunction

    function automatic logic amss_mux(input logic [2:0] s, input logic [5:0] pins);
        unique case (s)
            AMSS_SEL_ZERO:   return 1'b0;
            AMSS_SEL_D7:     return pins[0];
            AMSS_SEL_D8:     return pins[1];
            AMSS_SEL_D9:     return pins[2];
            AMSS_SEL_RSVD:   return 1'b0;
            AMSS_SEL_S0SIMO: return pins[3];
            AMSS_SEL_S0SCS:  return pins[4];
            AMSS_SEL_S0ENA:  return pins[5];
        endcase
        return 1'b0;
    endfunction

    // ------------------------------------------------------------
    // source mux and synchronizers
    // ------------------------------------------------------------
    logic [5:0]             pins;
    logic [AMSS_NPORTS-1:0] raw_mute;
    logic [AMSS_NPORTS-1:0] sync_mute;

    assign pins = {first_spi_enable_i2c_data_pin, first_spi_chip_select_i2c_clock_pin,
                   first_spi_slave_in_pin, data9_second_spi_slave_in_pin,
                   data8_second_spi_slave_out_pin, data7_second_spi_clock_pin};

    genvar g;
    generate
        for (g = 0; g < AMSS_NPORTS; g++) begin : g_port
            // mux before the synchronizer so a selector change settles too
            assign raw_mute[g] = amss_mux(st.sel[g], pins);
            amss_sync u_sync (
                .pclk    (pclk),
                .presetn (presetn),
                .din     (raw_mute[g]),
                .dout    (sync_mute[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // bit clock classification
    // ------------------------------------------------------------
    amss_clk_class_t tx_cls;
    amss_clk_class_t rx_cls;

    amss_clkclass u_txcls (
        .mode    (st.clkmode[AMSS_CM_TXM]),
        .dir_out (st.clkmode[AMSS_CM_TXD]),
        .cls     (tx_cls)
    );

    amss_clkclass u_rxcls (
        .mode    (st.clkmode[AMSS_CM_RXM]),
        .dir_out (st.clkmode[AMSS_CM_RXD]),
        .cls     (rx_cls)
    );

    // ------------------------------------------------------------
    // apb slave and registered outputs
    // ------------------------------------------------------------
    logic access;
    int   pidx;

    assign access = psel && penable && !st.ready;

    always_comb begin
        pidx          = amss_port_index(paddr);
        next_st       = st;
        next_st.ready = 1'b0;
        next_st.err   = 1'b0;
        next_st.mute  = sync_mute;
        next_st.txcls = tx_cls;
        next_st.rxcls = rx_cls;
        if (access) begin
            next_st.ready = 1'b1;
            next_st.rdata = '0;
            if (pidx >= 0) begin
                if (pwrite) begin
                    // upper bits dropped; software keeps them zero
                    next_st.sel[pidx] = pwdata[AMSS_SEL_W-1:0];
                end else begin
                    next_st.rdata[AMSS_SEL_W-1:0] = st.sel[pidx];
                end
            end else if (paddr == AMSS_ADDR_CLKMODE) begin
                if (pwrite) begin
                    next_st.clkmode = pwdata[3:0];
                end else begin
                    next_st.rdata[3:0] = st.clkmode;
                end
            end else begin
                next_st.err = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st       <= '0;
            st.sel   <= {AMSS_NPORTS{AMSS_SEL_RESET}};
            st.txcls <= AMSS_CLK_EXT_IN;
            st.rxcls <= AMSS_CLK_EXT_IN;
        end else begin
            st <= next_st;
        end
    end

    assign prdata               = st.rdata;
    assign pready               = st.ready;
    assign pslverr              = st.err;
    assign mute_in_port0        = st.mute[0];
    assign mute_in_port1        = st.mute[1];
    assign mute_in_port2        = st.mute[2];
    assign transmit_clock_class = st.txcls;
    assign receive_clock_class  = st.rxcls;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_zero_sel_mute: assert property (@(posedge pclk) disable iff (!presetn)
        (st.sel[0] == AMSS_SEL_ZERO) [*4] |-> !mute_in_port0)
        else $error("port0 mute high with zero selector");

    chk_rsvd_sel_mute: assert property (@(posedge pclk) disable iff (!presetn)
        (st.sel[1] == AMSS_SEL_RSVD) [*4] |-> !mute_in_port1)
        else $error("port1 mute high with reserved selector");

    chk_d7_path_lat: assert property (@(posedge pclk) disable iff (!presetn)
        (st.sel[0] == AMSS_SEL_D7) [*4] |->
        mute_in_port0 == $past(data7_second_spi_clock_pin, 3))
        else $error("port0 mute does not follow data line 7 pin");

    chk_d8_path_lat: assert property (@(posedge pclk) disable iff (!presetn)
        (st.sel[2] == AMSS_SEL_D8) [*4] |->
        mute_in_port2 == $past(data8_second_spi_slave_out_pin, 3))
        else $error("port2 mute does not follow data line 8 pin");

    chk_d9_path_lat: assert property (@(posedge pclk) disable iff (!presetn)
        (st.sel[1] == AMSS_SEL_D9) [*4] |->
        mute_in_port1 == $past(data9_second_spi_slave_in_pin, 3))
        else $error("port1 mute does not follow data line 9 pin");

    chk_simo_path_lat: assert property (@(posedge pclk) disable iff (!presetn)
        (st.sel[0] == AMSS_SEL_S0SIMO) [*4] |->
        mute_in_port0 == $past(first_spi_slave_in_pin, 3))
        else $error("port0 mute does not follow first spi slave-in");

    chk_scs_path_lat: assert property (@(posedge pclk) disable iff (!presetn)
        (st.sel[2] == AMSS_SEL_S0SCS) [*4] |->
        mute_in_port2 == $past(first_spi_chip_select_i2c_clock_pin, 3))
        else $error("port2 mute does not follow chip select pin");

    chk_ena_path_lat: assert property (@(posedge pclk) disable iff (!presetn)
        (st.sel[1] == AMSS_SEL_S0ENA) [*4] |->
        mute_in_port1 == $past(first_spi_enable_i2c_data_pin, 3))
        else $error("port1 mute does not follow enable handshake pin");

    chk_sel_write_read: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == AMSS_ADDR_PORT1) |=>
        st.sel[1] == $past(pwdata[2:0]))
        else $error("selector write not stored");

    chk_rsvd_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pwrite && pidx >= 0) |=> prdata[31:3] == '0 && pready)
        else $error("reserved selector bits not zero on read");

    chk_tx_class_map: assert property (@(posedge pclk) disable iff (!presetn)
        (st.clkmode[AMSS_CM_TXM] && st.clkmode[AMSS_CM_TXD]) [*2] |->
        transmit_clock_class == AMSS_CLK_INT)
        else $error("transmit clock not internal");

    chk_rx_class_map: assert property (@(posedge pclk) disable iff (!presetn)
        (!st.clkmode[AMSS_CM_RXM] && st.clkmode[AMSS_CM_RXD]) [*2] |->
        receive_clock_class == AMSS_CLK_EXT_OUT)
        else $error("receive clock not external output");

endmodule // amss_top

// ---- dv/amss_pin_model.sv ----
// model of the external pins that may carry mute or error signals
module amss_pin_model (
    input  wire logic       pclk,
    input  wire logic       slow,
    output logic      [5:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div;
    initial begin
        pins = 6'h00;
        div  = 2'h0;
    end
    // slow mode holds a level for four cycles, as a real mute line would
    always @(posedge pclk) begin
        div <= div + 2'h1;
        if (!slow || div == 2'h0) begin
            pins <= 6'($urandom);
        end
    end
endmodule // amss_pin_model

// ---- dv/tb_amss_top.sv ----
// self-checking testbench for the audio mute source select block
module tb_amss_top import amss_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [5:0]  pins;
    logic [2:0]  mute, tx_cls, rx_cls, code, exp_sel[3];
    logic [2:0][5:0] hist;
    logic        err;
    int          n_fail, check_count, cyc, calm_at, seed;
    logic [31:0] port_addr[3] = '{AMSS_ADDR_PORT0, AMSS_ADDR_PORT1, AMSS_ADDR_PORT2};

    amss_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .data7_second_spi_clock_pin(pins[0]),
        .data8_second_spi_slave_out_pin(pins[1]), .data9_second_spi_slave_in_pin(pins[2]),
        .first_spi_slave_in_pin(pins[3]), .first_spi_chip_select_i2c_clock_pin(pins[4]),
        .first_spi_enable_i2c_data_pin(pins[5]), .mute_in_port0(mute[0]),
        .mute_in_port1(mute[1]), .mute_in_port2(mute[2]),
        .transmit_clock_class(tx_cls), .receive_clock_class(rx_cls));
    amss_pin_model pin_model (.pclk(pclk), .slow(slow), .pins(pins));

    always #12.5 pclk = ~pclk;

    // ----------------------------------------
    // expectations and comparisons
    // ----------------------------------------
    function automatic logic sel_mux(input logic [2:0] s, input logic [5:0] p);
        case (s)
            AMSS_SEL_D7:     return p[0];
            AMSS_SEL_D8:     return p[1];
            AMSS_SEL_D9:     return p[2];
            AMSS_SEL_S0SIMO: return p[3];
            AMSS_SEL_S0SCS:  return p[4];
            AMSS_SEL_S0ENA:  return p[5];
            default:         return 1'b0;
        endcase
    endfunction
    function automatic logic [2:0] cls_of(input logic m, input logic d);
        if (m && d) return AMSS_CLK_INT;
        return (!m && d) ? AMSS_CLK_EXT_OUT : AMSS_CLK_EXT_IN;
    endfunction
    task automatic check_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic check_bit(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic conclude();
        $display("TB: %0d checks, %0d mismatches", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // mute follows the source three edges late; skipped while a selector settles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        hist <= {hist[1:0], pins};
        if (cyc > calm_at) begin
            for (int k = 0; k < 3; k++) begin
                check_bit("mute_in_port", sel_mux(exp_sel[k], hist[2]), mute[k]);
            end
        end
    end

    // ----------------------------------------
    // apb master
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED pready expected 1 seen %b", pready);
            conclude();
        end
        @(posedge pclk);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        for (int p = 0; p < 3; p++) begin
            if (a == port_addr[p]) exp_sel[p] = d[2:0];
        end
        calm_at = cyc + 6;
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0000_0000);
        check_reg("prdata", e, rd);
        check_reg("pslverr", {31'h0, ee}, {31'h0, err});
    endtask

    initial begin
        seed = $urandom(32'hD539D9E7);
        {pclk, psel, penable, pwrite, slow} = 5'h00;
        {paddr, pwdata} = 64'h0;
        presetn = 1'b0;
        calm_at = 1 << 30;
        cyc = 0;
        exp_sel = '{3'h0, 3'h0, 3'h0};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        calm_at = cyc + 5;
        for (int p = 0; p < 3; p++) rd_chk(port_addr[p], 32'h0, 1'b0);
        rd_chk(AMSS_ADDR_CLKMODE, 32'h0, 1'b0);
        rd_chk(32'h4000_0028, 32'h0, 1'b1);
        $display("TB: reset values done");
        for (int i = 0; i < 14; i++) begin
            for (int p = 0; p < 3; p++) begin
                code = (i < 8) ? 3'(i + 3 * p) : 3'($urandom);
                // the sweep hits the reserved code on purpose; random draws never do
                if (i >= 8 && code == AMSS_SEL_RSVD) code = AMSS_SEL_ZERO;
                wr(port_addr[p], {29'h0, code});
                rd_chk(port_addr[p], {29'h0, code}, 1'b0);
            end
            wr(32'h4000_0000 | 32'($urandom_range(40, 255)) << 2, $urandom);
            slow <= i[0];
            repeat (24) @(posedge pclk);
        end
        for (int p = 0; p < 3; p++) rd_chk(port_addr[p], {29'h0, exp_sel[p]}, 1'b0);
        $display("TB: source select done");
        for (int v = 0; v < 16; v++) begin
            wr(AMSS_ADDR_CLKMODE, 32'(v));
            @(posedge pclk);
            check_reg("transmit_clock_class", {29'h0, cls_of(v[0], v[1])}, {29'h0, tx_cls});
            check_reg("receive_clock_class", {29'h0, cls_of(v[2], v[3])}, {29'h0, rx_cls});
        end
        $display("TB: clock classes done");
        presetn <= 1'b0;
        calm_at = 1 << 30;
        repeat (2) @(posedge pclk);
        check_reg("mute_during_reset", 32'h0, {29'h0, mute});
        presetn <= 1'b1;
        exp_sel = '{3'h0, 3'h0, 3'h0};
        calm_at = cyc + 5;
        for (int p = 0; p < 3; p++) rd_chk(port_addr[p], 32'h0, 1'b0);
        repeat (10) @(posedge pclk);
        $display("TB: second reset done");
        conclude();
    end
endmodule // tb_amss_top
